// *** rtl/vertical_crt_timing_ext.sv ***
// Behaviour
// - Sync ends when low four bits match
// - Sync pulse lasts at most sixteen lines
// - Sync start bits 9,8 from A[7],A[2]
// - Display end bits 9,8 from A[6],A[1]
// - Total bits 9,8 from A[5],A[0]
// - A[4] mirrors standard overflow bit four
// - Blank start bit 8 from A[3]
// - Total bit 10 from B[0]
// - Display end bit 10 from B[1]
// - Sync start bit 10 from B[4]
// - Blank start bits 9,10 from B[2],B[3]
// - Odd field sync delayed by skew
// - Skew counts whole character clocks
// - Twenty-bit start address, high nibble extension
// - Working set, lock bit gates standard writes
// - Polarity source selects extension or misc
`timescale 1ns/10ps
module vertical_crt_timing_ext (
  input wire logic clk,
  input wire logic rst_b,
  input wire vtiming_pkg::reg_access_type access,
  input wire logic char_en,
  input wire logic line_en,
  input wire logic [7:0] misc_output,
  input wire logic hsync_raw,
  output logic [7:0] read_data,
  output logic vsync,
  output logic hsync,
  output logic vblank,
  output logic vdisplay,
  output logic odd_field,
  output logic [19:0] start_address,
  output logic [10:0] line_compare
);
  logic [7:0] vt_reg, vt_next;
  logic [7:0] de_reg, de_next;
  logic [7:0] bs_reg, bs_next;
  logic [7:0] be_reg, be_next;
  logic [7:0] ss_reg, ss_next;
  logic [7:0] se_reg, se_next;
  logic [7:0] ova_reg, ova_next;
  logic [7:0] ovb_reg, ovb_next;
  logic [7:0] skew_reg, skew_next;
  logic [7:0] sah_reg, sah_next;
  logic [7:0] pol_reg, pol_next;
  logic [7:0] mode_reg, mode_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] std_vt_reg, std_vt_next;
  logic [7:0] std_ov_reg, std_ov_next;
  logic [7:0] std_sah_reg, std_sah_next;
  logic [7:0] std_sal_reg, std_sal_next;
  logic [7:0] std_ss_reg, std_ss_next;
  logic [7:0] std_se_reg, std_se_next;
  logic [7:0] std_de_reg, std_de_next;
  logic [7:0] std_bs_reg, std_bs_next;
  logic [7:0] std_be_reg, std_be_next;
  logic [7:0] lc_reg, lc_next;
  logic [7:0] rd_reg, rd_next;
  logic vsync_reg, vsync_next;
  logic hsync_reg, hsync_next;
  logic vblank_reg, vblank_next;
  logic vdisp_reg, vdisp_next;
  logic odd_reg, odd_next;
  logic [19:0] start_reg, start_next;
  logic [10:0] lcmp_reg, lcmp_next;
  logic raw_sync_reg, raw_sync_next;
  vtiming_pkg::vtiming_type tim;
  logic [10:0] line;
  logic frame_start;
  logic skewed_sync;
  logic ext_wr, std_wr, pass;

  assign ext_wr = access.write && access.extension;
  assign std_wr = access.write && !access.extension;
  assign pass = std_wr && !ctrl_reg[vtiming_pkg::CTRL_WORKING_LOCK];

  // Register writes; standard writes echo into working set when unlocked
  always_comb begin
    vt_next = vt_reg; de_next = de_reg; bs_next = bs_reg; be_next = be_reg;
    ss_next = ss_reg; se_next = se_reg; ova_next = ova_reg;
    ovb_next = ovb_reg; skew_next = skew_reg; sah_next = sah_reg;
    pol_next = pol_reg; mode_next = mode_reg; ctrl_next = ctrl_reg;
    std_vt_next = std_vt_reg; std_ov_next = std_ov_reg;
    std_sah_next = std_sah_reg; std_sal_next = std_sal_reg;
    std_ss_next = std_ss_reg; std_se_next = std_se_reg;
    std_de_next = std_de_reg; std_bs_next = std_bs_reg;
    std_be_next = std_be_reg; lc_next = lc_reg;
    if (ext_wr) begin
      case (access.index)
        vtiming_pkg::VERTICAL_TOTAL_LOW_IDX: vt_next = access.data;
        vtiming_pkg::DISPLAY_END_LOW_IDX: de_next = access.data;
        vtiming_pkg::BLANK_START_LOW_IDX: bs_next = access.data;
        vtiming_pkg::BLANK_END_IDX: be_next = access.data;
        vtiming_pkg::SYNC_START_LOW_IDX: ss_next = access.data;
        vtiming_pkg::VERTICAL_SYNC_END_IDX:
          se_next = access.data & vtiming_pkg::SYNC_END_MASK;
        vtiming_pkg::VERTICAL_OVERFLOW_A_IDX: begin
          ova_next = access.data;
          std_ov_next[vtiming_pkg::OVA_LCMP8] =
            access.data[vtiming_pkg::OVA_LCMP8];
        end
        vtiming_pkg::VERTICAL_OVERFLOW_B_IDX:
          ovb_next = access.data & vtiming_pkg::OVERFLOW_B_MASK;
        vtiming_pkg::ODD_FIELD_SYNC_SKEW_IDX: skew_next = access.data;
        vtiming_pkg::SCREEN_A_START_HIGH_IDX:
          sah_next = access.data & vtiming_pkg::START_HIGH_MASK;
        vtiming_pkg::POLARITY_CONTROL_IDX:
          pol_next = access.data & vtiming_pkg::POLARITY_MASK;
        vtiming_pkg::DISPLAY_MODE_IDX:
          mode_next = access.data & vtiming_pkg::MODE_INTERLACE_MASK;
        vtiming_pkg::WORKING_SET_CONTROL_IDX:
          ctrl_next = access.data & vtiming_pkg::WORKING_CTRL_MASK;
        default: ;
      endcase
    end
    if (std_wr) begin
      case (access.index)
        vtiming_pkg::STD_VERTICAL_TOTAL_IDX: std_vt_next = access.data;
        vtiming_pkg::STD_OVERFLOW_IDX: begin
          std_ov_next = access.data;
          ova_next[vtiming_pkg::OVA_LCMP8] =
            access.data[vtiming_pkg::OVA_LCMP8];
        end
        vtiming_pkg::STD_START_HIGH_IDX: std_sah_next = access.data;
        vtiming_pkg::STD_START_LOW_IDX: std_sal_next = access.data;
        vtiming_pkg::STD_SYNC_START_IDX: std_ss_next = access.data;
        vtiming_pkg::STD_SYNC_END_IDX: std_se_next = access.data;
        vtiming_pkg::STD_DISPLAY_END_IDX: std_de_next = access.data;
        vtiming_pkg::STD_BLANK_START_IDX: std_bs_next = access.data;
        vtiming_pkg::STD_BLANK_END_IDX: std_be_next = access.data;
        vtiming_pkg::LINE_COMPARE_LOW_IDX: lc_next = access.data;
        default: ;
      endcase
    end
    if (pass) begin
      case (access.index)
        vtiming_pkg::STD_VERTICAL_TOTAL_IDX: vt_next = access.data;
        vtiming_pkg::STD_OVERFLOW_IDX: ova_next = access.data;
        vtiming_pkg::STD_SYNC_START_IDX: ss_next = access.data;
        vtiming_pkg::STD_SYNC_END_IDX:
          se_next = access.data & vtiming_pkg::SYNC_END_MASK;
        vtiming_pkg::STD_DISPLAY_END_IDX: de_next = access.data;
        vtiming_pkg::STD_BLANK_START_IDX: bs_next = access.data;
        vtiming_pkg::STD_BLANK_END_IDX: be_next = access.data;
        default: ;
      endcase
    end
  end

  // Read mux; reserved bits already held at zero
  always_comb begin
    rd_next = rd_reg;
    if (access.read) begin
      if (access.extension) begin
        case (access.index)
          vtiming_pkg::VERTICAL_TOTAL_LOW_IDX: rd_next = vt_reg;
          vtiming_pkg::DISPLAY_END_LOW_IDX: rd_next = de_reg;
          vtiming_pkg::BLANK_START_LOW_IDX: rd_next = bs_reg;
          vtiming_pkg::BLANK_END_IDX: rd_next = be_reg;
          vtiming_pkg::SYNC_START_LOW_IDX: rd_next = ss_reg;
          vtiming_pkg::VERTICAL_SYNC_END_IDX: rd_next = se_reg;
          vtiming_pkg::VERTICAL_OVERFLOW_A_IDX: rd_next = ova_reg;
          vtiming_pkg::VERTICAL_OVERFLOW_B_IDX: rd_next = ovb_reg;
          vtiming_pkg::ODD_FIELD_SYNC_SKEW_IDX: rd_next = skew_reg;
          vtiming_pkg::SCREEN_A_START_HIGH_IDX: rd_next = sah_reg;
          vtiming_pkg::POLARITY_CONTROL_IDX: rd_next = pol_reg;
          vtiming_pkg::DISPLAY_MODE_IDX: rd_next = mode_reg;
          vtiming_pkg::WORKING_SET_CONTROL_IDX: rd_next = ctrl_reg;
          default: rd_next = 8'h00;
        endcase
      end else begin
        case (access.index)
          vtiming_pkg::STD_VERTICAL_TOTAL_IDX: rd_next = std_vt_reg;
          vtiming_pkg::STD_OVERFLOW_IDX: rd_next = std_ov_reg;
          vtiming_pkg::STD_START_HIGH_IDX: rd_next = std_sah_reg;
          vtiming_pkg::STD_START_LOW_IDX: rd_next = std_sal_reg;
          vtiming_pkg::STD_SYNC_START_IDX: rd_next = std_ss_reg;
          vtiming_pkg::STD_SYNC_END_IDX: rd_next = std_se_reg;
          vtiming_pkg::STD_DISPLAY_END_IDX: rd_next = std_de_reg;
          vtiming_pkg::STD_BLANK_START_IDX: rd_next = std_bs_reg;
          vtiming_pkg::STD_BLANK_END_IDX: rd_next = std_be_reg;
          vtiming_pkg::LINE_COMPARE_LOW_IDX: rd_next = lc_reg;
          default: rd_next = 8'h00;
        endcase
      end
    end
  end

  // Assemble the 11-bit working values
  always_comb begin
    tim.total = {ovb_reg[vtiming_pkg::OVB_TOTAL10],
      ova_reg[vtiming_pkg::OVA_TOTAL9], ova_reg[vtiming_pkg::OVA_TOTAL8],
      vt_reg};
    // display end bits 10 to 8
    tim.display_end = {ovb_reg[vtiming_pkg::OVB_DISP10],
      ova_reg[vtiming_pkg::OVA_DISP9], ova_reg[vtiming_pkg::OVA_DISP8],
      de_reg};
    // blank start bits 10 to 8
    tim.blank_start = {ovb_reg[vtiming_pkg::OVB_BLANK10],
      ovb_reg[vtiming_pkg::OVB_BLANK9], ova_reg[vtiming_pkg::OVA_BLANK8],
      bs_reg};
    tim.blank_end = be_reg;
    // sync start bits 10 to 8
    tim.sync_start = {ovb_reg[vtiming_pkg::OVB_SYNC10],
      ova_reg[vtiming_pkg::OVA_SYNC9], ova_reg[vtiming_pkg::OVA_SYNC8],
      ss_reg};
    tim.sync_end = se_reg[3:0];
  end

  // counter wraps at total plus two lines
  vline_counter #(
    .WIDTH(vtiming_pkg::LINE_WIDTH)
  ) u_lines (
    .clk(clk),
    .rst_b(rst_b),
    .line_en(line_en),
    .total(tim.total),
    .line(line),
    .frame_start(frame_start)
  );

  // Raw sync, blank, display and field tracking
  always_comb begin
    raw_sync_next = raw_sync_reg;
    vblank_next = vblank_reg;
    odd_next = odd_reg;
    vdisp_next = (line < tim.display_end);
    if (frame_start && mode_reg[vtiming_pkg::MODE_INTERLACE]) begin
      odd_next = !odd_reg;
    end else if (!mode_reg[vtiming_pkg::MODE_INTERLACE]) begin
      odd_next = 1'b0;
    end
    if (line == tim.sync_start) begin
      raw_sync_next = 1'b1;
    end else if (line[3:0] == tim.sync_end) begin
      raw_sync_next = 1'b0;
    end
    if (line == tim.blank_start) begin
      vblank_next = 1'b1;
    end else if (line[7:0] == tim.blank_end) begin
      vblank_next = 1'b0;
    end
  end

  // odd field delayed by char clocks
  vsync_skew #(
    .WIDTH(vtiming_pkg::SKEW_WIDTH)
  ) u_skew (
    .clk(clk),
    .rst_b(rst_b),
    .char_en(char_en),
    .sync_in(raw_sync_reg),
    .skew_enable(mode_reg[vtiming_pkg::MODE_INTERLACE] && odd_reg),
    .skew(skew_reg),
    .sync_out(skewed_sync)
  );

  // Output polarity and address assembly
  always_comb begin
    if (pol_reg[vtiming_pkg::POL_SOURCE]) begin
      vsync_next = skewed_sync ^ pol_reg[vtiming_pkg::POL_VERT];
      hsync_next = hsync_raw ^ pol_reg[vtiming_pkg::POL_HORZ];
    end else begin
      vsync_next = skewed_sync ^ misc_output[vtiming_pkg::MISC_VPOL];
      hsync_next = hsync_raw ^ misc_output[vtiming_pkg::MISC_HPOL];
    end
    start_next = {sah_reg[3:0], std_sah_reg, std_sal_reg};
    lcmp_next = {2'b00, std_ov_reg[vtiming_pkg::OVA_LCMP8], lc_reg};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vt_reg <= vtiming_pkg::RESET_VALUE; de_reg <= vtiming_pkg::RESET_VALUE;
      bs_reg <= vtiming_pkg::RESET_VALUE; be_reg <= vtiming_pkg::RESET_VALUE;
      ss_reg <= vtiming_pkg::RESET_VALUE; se_reg <= vtiming_pkg::RESET_VALUE;
      ova_reg <= vtiming_pkg::RESET_VALUE;
      ovb_reg <= vtiming_pkg::RESET_VALUE;
      skew_reg <= vtiming_pkg::RESET_VALUE;
      sah_reg <= vtiming_pkg::RESET_VALUE;
      pol_reg <= vtiming_pkg::RESET_VALUE;
      mode_reg <= vtiming_pkg::RESET_VALUE;
      ctrl_reg <= vtiming_pkg::RESET_VALUE;
      std_vt_reg <= vtiming_pkg::RESET_VALUE;
      std_ov_reg <= vtiming_pkg::RESET_VALUE;
      std_sah_reg <= vtiming_pkg::RESET_VALUE;
      std_sal_reg <= vtiming_pkg::RESET_VALUE;
      std_ss_reg <= vtiming_pkg::RESET_VALUE;
      std_se_reg <= vtiming_pkg::RESET_VALUE;
      std_de_reg <= vtiming_pkg::RESET_VALUE;
      std_bs_reg <= vtiming_pkg::RESET_VALUE;
      std_be_reg <= vtiming_pkg::RESET_VALUE;
      lc_reg <= vtiming_pkg::RESET_VALUE;
      rd_reg <= vtiming_pkg::RESET_VALUE;
      vsync_reg <= 1'b0; hsync_reg <= 1'b0; vblank_reg <= 1'b0;
      vdisp_reg <= 1'b0; odd_reg <= 1'b0; raw_sync_reg <= 1'b0;
      start_reg <= '0; lcmp_reg <= '0;
    end else begin
      vt_reg <= vt_next; de_reg <= de_next; bs_reg <= bs_next;
      be_reg <= be_next; ss_reg <= ss_next; se_reg <= se_next;
      ova_reg <= ova_next; ovb_reg <= ovb_next; skew_reg <= skew_next;
      sah_reg <= sah_next; pol_reg <= pol_next; mode_reg <= mode_next;
      ctrl_reg <= ctrl_next; std_vt_reg <= std_vt_next;
      std_ov_reg <= std_ov_next; std_sah_reg <= std_sah_next;
      std_sal_reg <= std_sal_next; std_ss_reg <= std_ss_next;
      std_se_reg <= std_se_next; std_de_reg <= std_de_next;
      std_bs_reg <= std_bs_next; std_be_reg <= std_be_next;
      lc_reg <= lc_next; rd_reg <= rd_next;
      vsync_reg <= vsync_next; hsync_reg <= hsync_next;
      vblank_reg <= vblank_next; vdisp_reg <= vdisp_next;
      odd_reg <= odd_next; raw_sync_reg <= raw_sync_next;
      start_reg <= start_next; lcmp_reg <= lcmp_next;
    end
  end

  assign read_data = rd_reg;
  assign vsync = vsync_reg;
  assign hsync = hsync_reg;
  assign vblank = vblank_reg;
  assign vdisplay = vdisp_reg;
  assign odd_field = odd_reg;
  assign start_address = start_reg;
  assign line_compare = lcmp_reg;
endmodule : vertical_crt_timing_ext

// *** rtl/vtiming_pkg.sv ***
package vtiming_pkg;
  // Extension register indices
  localparam logic [7:0] VERTICAL_TOTAL_LOW_IDX = 8'h70;
  localparam logic [7:0] DISPLAY_END_LOW_IDX = 8'h71;
  localparam logic [7:0] BLANK_START_LOW_IDX = 8'h72;
  localparam logic [7:0] BLANK_END_IDX = 8'h73;
  localparam logic [7:0] SYNC_START_LOW_IDX = 8'h74;
  localparam logic [7:0] VERTICAL_SYNC_END_IDX = 8'h75;
  localparam logic [7:0] VERTICAL_OVERFLOW_A_IDX = 8'h78;
  localparam logic [7:0] VERTICAL_OVERFLOW_B_IDX = 8'h79;
  localparam logic [7:0] ODD_FIELD_SYNC_SKEW_IDX = 8'h7a;
  localparam logic [7:0] SCREEN_A_START_HIGH_IDX = 8'h7c;
  localparam logic [7:0] POLARITY_CONTROL_IDX = 8'h80;
  localparam logic [7:0] DISPLAY_MODE_IDX = 8'h81;
  localparam logic [7:0] WORKING_SET_CONTROL_IDX = 8'h83;
  // Standard register indices
  localparam logic [7:0] STD_VERTICAL_TOTAL_IDX = 8'h06;
  localparam logic [7:0] STD_OVERFLOW_IDX = 8'h07;
  localparam logic [7:0] STD_START_HIGH_IDX = 8'h0c;
  localparam logic [7:0] STD_START_LOW_IDX = 8'h0d;
  localparam logic [7:0] STD_SYNC_START_IDX = 8'h10;
  localparam logic [7:0] STD_SYNC_END_IDX = 8'h11;
  localparam logic [7:0] STD_DISPLAY_END_IDX = 8'h12;
  localparam logic [7:0] STD_BLANK_START_IDX = 8'h15;
  localparam logic [7:0] STD_BLANK_END_IDX = 8'h16;
  localparam logic [7:0] LINE_COMPARE_LOW_IDX = 8'h18;
  // Writable masks and reset value
  localparam logic [7:0] SYNC_END_MASK = 8'h0f;
  localparam logic [7:0] OVERFLOW_B_MASK = 8'h1f;
  localparam logic [7:0] START_HIGH_MASK = 8'h0f;
  localparam logic [7:0] POLARITY_MASK = 8'hf0;
  localparam logic [7:0] MODE_INTERLACE_MASK = 8'h04;
  localparam logic [7:0] WORKING_CTRL_MASK = 8'h01;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Overflow A field positions
  localparam int OVA_SYNC9 = 7;
  localparam int OVA_DISP9 = 6;
  localparam int OVA_TOTAL9 = 5;
  localparam int OVA_LCMP8 = 4;
  localparam int OVA_BLANK8 = 3;
  localparam int OVA_SYNC8 = 2;
  localparam int OVA_DISP8 = 1;
  localparam int OVA_TOTAL8 = 0;
  // Overflow B field positions
  localparam int OVB_SYNC10 = 4;
  localparam int OVB_BLANK10 = 3;
  localparam int OVB_BLANK9 = 2;
  localparam int OVB_DISP10 = 1;
  localparam int OVB_TOTAL10 = 0;
  // Polarity, mode, control and misc positions, and widths
  localparam int POL_VERT = 7;
  localparam int POL_HORZ = 6;
  localparam int POL_SOURCE = 5;
  localparam int MODE_INTERLACE = 2;
  localparam int CTRL_WORKING_LOCK = 0;
  localparam int MISC_VPOL = 7;
  localparam int MISC_HPOL = 6;
  localparam int LINE_WIDTH = 11;
  localparam int SKEW_WIDTH = 8;
  localparam int START_WIDTH = 20;

  typedef struct packed {
    logic write;
    logic read;
    logic extension;
    logic [7:0] index;
    logic [7:0] data;
  } reg_access_type;

  typedef struct packed {
    logic [10:0] total;
    logic [10:0] display_end;
    logic [10:0] blank_start;
    logic [7:0] blank_end;
    logic [10:0] sync_start;
    logic [3:0] sync_end;
  } vtiming_type;
endpackage : vtiming_pkg

// *** rtl/vsync_skew.sv ***
`timescale 1ns/10ps
module vsync_skew #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic char_en,
  input wire logic sync_in,
  input wire logic skew_enable,
  input wire logic [WIDTH-1:0] skew,
  output logic sync_out
);
  typedef enum logic [1:0] {
    IDLE_S = 2'b00,
    RISE_S = 2'b01,
    HIGH_S = 2'b11,
    FALL_S = 2'b10
  } skew_state_type;

  skew_state_type state_reg, state_next;
  logic [WIDTH-1:0] count_reg, count_next;
  logic out_reg, out_next;
  logic in_reg, in_next;

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    out_next = out_reg;
    in_next = in_reg;
    if (char_en) begin
      in_next = sync_in;
      case (state_reg)
        IDLE_S: begin
          if (sync_in && !in_reg) begin
            count_next = skew;
            if (!skew_enable || skew == '0) begin
              out_next = 1'b1;
              state_next = HIGH_S;
            end else begin
              state_next = RISE_S;
            end
          end
        end
        RISE_S: begin
          if (count_reg <= WIDTH'(1)) begin
            out_next = 1'b1;
            state_next = HIGH_S;
          end else begin
            count_next = count_reg - WIDTH'(1);
          end
        end
        HIGH_S: begin
          if (!sync_in && in_reg) begin
            if (!skew_enable || count_reg == '0) begin
              out_next = 1'b0;
              state_next = IDLE_S;
            end else begin
              count_next = skew;
              state_next = FALL_S;
            end
          end
        end
        FALL_S: begin
          if (count_reg <= WIDTH'(1)) begin
            out_next = 1'b0;
            state_next = IDLE_S;
          end else begin
            count_next = count_reg - WIDTH'(1);
          end
        end
        default: begin
          state_next = IDLE_S;
          out_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= IDLE_S;
      count_reg <= '0;
      out_reg <= 1'b0;
      in_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      out_reg <= out_next;
      in_reg <= in_next;
    end
  end

  assign sync_out = out_reg;
endmodule : vsync_skew

// *** rtl/vline_counter.sv ***
`timescale 1ns/10ps
module vline_counter #(
  parameter int WIDTH = 11
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic line_en,
  input wire logic [WIDTH-1:0] total,
  output logic [WIDTH-1:0] line,
  output logic frame_start
);
  logic [WIDTH-1:0] line_reg, line_next;
  logic start_reg, start_next;

  // Total is programmed as lines minus two, so wrap past total plus one
  always_comb begin
    line_next = line_reg;
    start_next = 1'b0;
    if (line_en) begin
      if (line_reg >= total + WIDTH'(1)) begin
        line_next = '0;
        start_next = 1'b1;
      end else begin
        line_next = line_reg + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_reg <= '0;
      start_reg <= 1'b0;
    end else begin
      line_reg <= line_next;
      start_reg <= start_next;
    end
  end

  assign line = line_reg;
  assign frame_start = start_reg;
endmodule : vline_counter

// *** dv/vtiming_assertions.sv ***
`timescale 1ns/10ps
module vtiming_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire vtiming_pkg::reg_access_type access,
  input wire logic [7:0] read_data,
  input wire logic [19:0] start_address,
  input wire logic [10:0] line_compare
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence acc(logic w, logic e, logic [7:0] i);
    (w ? access.write : access.read) && access.extension == e &&
      access.index == i;
  endsequence
  // Next cycle idle, so the value stays put for the check
  sequence wr_done(logic e, logic [7:0] i);
    acc(1'b1, e, i) ##1 !access.write;
  endsequence
  unmapped_read_a:
    assert property (acc(1'b0, 1'b1, 8'h77) |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  sync_end_rsvd_a:
    assert property (acc(1'b0, 1'b1, 8'h75) |=> read_data[7:4] == 4'h0)
    else $error("sync end upper bits set");
  overflow_b_rsvd_a:
    assert property (acc(1'b0, 1'b1, 8'h79) |=> read_data[7:5] == 3'h0)
    else $error("overflow b upper bits set");
  start_high_rsvd_a:
    assert property (acc(1'b0, 1'b1, 8'h7c) |=> read_data[7:4] == 4'h0)
    else $error("start high upper bits set");
  start_high_a:
    assert property (wr_done(1'b1, 8'h7c) |=>
      start_address[19:16] == $past(access.data[3:0], 2))
    else $error("start high nibble wrong");
  start_low_a:
    assert property (wr_done(1'b0, 8'h0d) |=>
      start_address[7:0] == $past(access.data, 2))
    else $error("start low byte wrong");
  lc_ext_mirror_a:
    assert property (wr_done(1'b1, 8'h78) |=>
      line_compare[8] == $past(access.data[4], 2))
    else $error("compare bit from ext write wrong");
  lc_std_mirror_a:
    assert property (wr_done(1'b0, 8'h07) |=>
      line_compare[8] == $past(access.data[4], 2))
    else $error("compare bit from std write wrong");
endmodule : vtiming_assertions
bind vertical_crt_timing_ext vtiming_assertions chk (.clk, .rst_b,
  .access, .read_data, .start_address, .line_compare);

// *** dv/crt_monitor.sv ***
`timescale 1ns/10ps
module crt_monitor (
  input wire logic clk,
  input wire logic line_en,
  input wire logic vsync,
  input wire logic vdisplay,
  output int width,
  output int period,
  output int gap,
  output int rises
);
  int w = 0;
  int p = 0;
  int g = 0;
  logic vs_d = 1'b0;
  logic vd_d = 1'b0;
  initial begin
    width = 0;
    period = 0;
    gap = 0;
    rises = 0;
  end
  // Everything counted in scanlines, as a monitor sees it
  always @(posedge clk) begin
    if (vsync && !vs_d) begin
      period = p;
      gap = g;
      rises++;
      p = 0;
      w = 0;
    end
    if (!vsync && vs_d) width = w;
    if (vd_d && !vdisplay) g = 0;
    if (line_en) begin
      p++;
      g++;
      if (vsync) w++;
    end
    vs_d = vsync;
    vd_d = vdisplay;
  end
endmodule : crt_monitor

// *** dv/vertical_crt_timing_ext_test.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module vertical_crt_timing_ext_test;
  logic clk, rst_b, char_en, line_en, vsync, vdisplay;
  logic hsync, vblank, odd_field;
  logic [7:0] misc_output, read_data;
  logic [2:0] cyc;
  logic [19:0] start_address;
  logic [10:0] line_compare;
  vtiming_pkg::reg_access_type access;
  int n_errors = 0;
  int compares = 0;
  int m_width, m_period, m_gap, m_rises;
  vertical_crt_timing_ext DUT (.clk, .rst_b, .access, .char_en, .line_en,
    .misc_output, .hsync_raw(1'b0), .read_data, .vsync, .hsync,
    .vblank, .vdisplay, .odd_field, .start_address, .line_compare);
  crt_monitor mon (.clk, .line_en, .vsync, .vdisplay, .width(m_width),
    .period(m_period), .gap(m_gap), .rises(m_rises));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    cyc = cyc + 3'h1;
    char_en = cyc[0];
    line_en = (cyc == 3'h7);
  end
  task automatic wr(logic e, logic [7:0] i, logic [7:0] d);
    @(posedge clk) #1 access = {1'b1, 1'b0, e, i, d};
    @(posedge clk) #1 access = '0;
  endtask : wr
  task automatic rd(logic e, logic [7:0] i, output logic [7:0] d);
    @(posedge clk) #1 access = {1'b0, 1'b1, e, i, 8'h00};
    @(posedge clk) #1 access = '0;
    d = read_data;
  endtask : rd
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] ix [5] = '{8'h75, 8'h78, 8'h79, 8'h7a, 8'h7c};
    logic [7:0] mk [5] = '{8'h0f, 8'hff, 8'h1f, 8'hff, 8'h0f};
    for (int k = 0; k < 5; k++) begin
      rd(1'b1, ix[k], d);
      `CHK(d, 8'h00)
      wr(1'b1, ix[k], 8'hff);
      rd(1'b1, ix[k], d);
      `CHK(d, mk[k])
    end
    rd(1'b0, 8'h07, d);
    `CHK(d[4], 1'b1)
    `CHK(line_compare[8], 1'b1)
    rd(1'b1, 8'h77, d);
    `CHK(d, 8'h00)
    wr(1'b0, 8'h0c, 8'h12);
    wr(1'b0, 8'h0d, 8'h34);
    @(posedge clk) #1;
    `CHK(start_address, 20'hf1234)
    wr(1'b0, 8'h07, 8'h00);
    rd(1'b1, 8'h78, d);
    `CHK(d[4], 1'b0)
    $display("register test done");
  endtask : t_regs
  task automatic t_working;
    logic [7:0] d;
    wr(1'b0, 8'h06, 8'h33);
    rd(1'b1, 8'h70, d);
    `CHK(d, 8'h33)
    wr(1'b1, 8'h83, 8'h01);
    wr(1'b0, 8'h06, 8'h44);
    rd(1'b1, 8'h70, d);
    `CHK(d, 8'h33)
    rd(1'b0, 8'h06, d);
    `CHK(d, 8'h44)
    $display("working set test done");
  endtask : t_working
  task automatic t_timing;
    int r0;
    wr(1'b1, 8'h70, 8'h10);
    wr(1'b1, 8'h71, 8'h00);
    wr(1'b1, 8'h74, 8'h05);
    wr(1'b1, 8'h75, 8'h08);
    wr(1'b1, 8'h78, 8'h00);
    // sync ends line 1032, blank ends 1040
    wr(1'b1, 8'h73, 8'h10);
    wr(1'b1, 8'h79, 8'h1b);
    r0 = m_rises;
    for (int n = 0; n < 40000 && m_rises < r0 + 3; n++) @(posedge clk);
    `CHK(m_rises - r0, 3)
    `CHK(m_period, 1042)
    `CHK(m_width, 3)
    `CHK(m_gap, 5)
    $display("timing test done");
  endtask : t_timing
  task automatic t_polarity;
    // Runs right after a sync rise, so sync is still high
    @(posedge clk) #1;
    `CHK({vsync, hsync, vblank}, 3'b101)
    misc_output = 8'hc0;
    @(posedge clk) #1;
    `CHK({vsync, hsync}, 2'b01)
    wr(1'b1, 8'h80, 8'h60);
    @(posedge clk) #1;
    `CHK({vsync, hsync}, 2'b11)
    misc_output = 8'h00;
    wr(1'b1, 8'h80, 8'h00);
    $display("polarity test done");
  endtask : t_polarity
  task automatic t_interlace;
    int r0, p1;
    logic o1;
    // skew of 1.5 lines puts odd lines halfway
    wr(1'b1, 8'h7a, 8'h06);
    wr(1'b1, 8'h81, 8'h04);
    r0 = m_rises;
    for (int n = 0; n < 40000 && m_rises < r0 + 2; n++) @(posedge clk);
    p1 = m_period;
    o1 = odd_field;
    for (int n = 0; n < 20000 && m_rises < r0 + 3; n++) @(posedge clk);
    `CHK(m_rises - r0, 3)
    `CHK(m_period + p1, 2084)
    `CHK((m_period - p1) * (m_period - p1), 4)
    `CHK(odd_field ^ o1, 1'b1)
    $display("interlace test done");
  endtask : t_interlace
  task print_verdict;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  initial begin
    rst_b = 0;
    access = '0;
    misc_output = 8'h00;
    cyc = 3'h0;
    char_en = 0;
    line_en = 0;
    repeat (5) @(posedge clk);
    #1 rst_b = 1;
    t_regs;
    t_working;
    t_timing;
    t_polarity;
    t_interlace;
    print_verdict;
  end
endmodule : vertical_crt_timing_ext_test
